// ---- verilog/ast_map.vh ----
// register offsets, field positions, reset values and timing counts
`ifndef AST_MAP_VH
`define AST_MAP_VH

`define AST_OFS_HOLD 8'h00
`define AST_OFS_TXCTL 8'h04
`define AST_OFS_BAUDCTL 8'h08
`define AST_OFS_DIVLO 8'h0C
`define AST_OFS_DIVHI 8'h10
`define AST_OFS_PFLAG 8'h14
`define AST_OFS_PEN 8'h18
`define AST_OFS_PORTCTL 8'h1C
`define AST_OFS_IRQST 8'h20
`define AST_OFS_IRQCTL 8'h24

`define AST_TXCTL_NINTHVAL 0
`define AST_TXCTL_SHEMPTY 1
`define AST_TXCTL_HIRATE 2
`define AST_TXCTL_SYNC 4
`define AST_TXCTL_TRANSMIT_ENABLE 5
`define AST_TXCTL_NINEEN 6
`define AST_BAUD_WIDE 3
`define AST_BAUD_INV 4
`define AST_PORT_SERIAL_PORT_ENABLE 7
`define AST_FLAG_TXBE 4
`define AST_FLAG_FRAME 1
`define AST_IRQ_GLOBAL 7
`define AST_IRQ_PERIPH 6

`define AST_RST_BYTE 8'h00
`define AST_RST_DIV 8'h00
`define AST_RST_WORD 32'h00000000

`define AST_OVS_LAST_LO 7'h3F
`define AST_OVS_LAST_HI 7'h0F
`define AST_BITS_EIGHT 4'hA
`define AST_BITS_NINE 4'hB
`define AST_XFER_CYC 1

`endif

// ---- verilog/ast_baud.v ----
// baud divider producing one bit-time enable pulse
`timescale 1ns/100ps
`default_nettype none
`include "ast_map.vh"

module ast_baud
(
    input wire sys_clk,
    input wire sys_rst,
    input wire run,
    input wire wide,
    input wire high,
    input wire [15:0] divisor,
    output reg bit_tick
);

reg [15:0] brg_cnt_r;
reg [6:0] ovs_cnt_r;
wire [6:0] ovs_last;
wire [15:0] reload;

// the generator output runs at x16 or x64 the bit rate
assign ovs_last = (wide | high) ? `AST_OVS_LAST_HI : `AST_OVS_LAST_LO;
assign reload = wide ? divisor : {8'h00, divisor[7:0]};

always @(posedge sys_clk)
begin
    if (sys_rst || !run)
    begin
        brg_cnt_r <= 16'h0000;
        ovs_cnt_r <= 7'h00;
        bit_tick <= 1'b0;
    end
    else
    begin
        bit_tick <= 1'b0;
        if (brg_cnt_r == 16'h0000)
        begin
            brg_cnt_r <= reload;
            if (ovs_cnt_r == ovs_last)
            begin
                ovs_cnt_r <= 7'h00;
                bit_tick <= 1'b1;
            end
            else
            begin
                ovs_cnt_r <= ovs_cnt_r + 7'h01;
            end
        end
        else
        begin
            brg_cnt_r <= brg_cnt_r - 16'h0001;
        end
    end
end

endmodule // ast_baud
`default_nettype wire

// ---- verilog/ast_shift.v ----
// frame shifter: start bit, 8 or 9 data bits lsb first, stop bit
`timescale 1ns/100ps
`default_nettype none
`include "ast_map.vh"

module ast_shift
(
    input wire sys_clk,
    input wire sys_rst,
    input wire abort,
    input wire bit_tick,
    input wire load,
    input wire nine,
    input wire [8:0] data,
    output wire line,
    output wire empty,
    output reg done
);

reg [10:0] sr_r;
reg [3:0] cnt_r;
reg busy_r;
reg started_r;
reg done_d_r;

assign line = (busy_r && started_r) ? sr_r[0] : 1'b1;
assign empty = ~busy_r;

always @(posedge sys_clk)
begin
    if (sys_rst || abort)
    begin
        sr_r <= 11'h7FF;
        cnt_r <= 4'h0;
        busy_r <= 1'b0;
        started_r <= 1'b0;
        done <= 1'b0;
        done_d_r <= 1'b0;
    end
    else
    begin
        done <= 1'b0;
        done_d_r <= done;
        if (load)
        begin
            // nrz frame, low start bit in front, high stop bit last
            sr_r <= {1'b1, nine ? data[8] : 1'b1, data[7:0], 1'b0};
            cnt_r <= nine ? `AST_BITS_NINE : `AST_BITS_EIGHT;
            busy_r <= 1'b1;
            // back-to-back frames start at once, no idle bit between
            started_r <= done_d_r;
        end
        else if (busy_r && bit_tick)
        begin
            if (!started_r)
            begin
                started_r <= 1'b1;
            end
            else
            begin
                sr_r <= {1'b1, sr_r[10:1]};
                cnt_r <= cnt_r - 4'h1;
                if (cnt_r == 4'h1)
                begin
                    busy_r <= 1'b0;
                    started_r <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
end

endmodule // ast_shift
`default_nettype wire

// ---- verilog/ast_top.v ----
// async serial transmitter with ahb-lite register slave
`timescale 1ns/100ps
`default_nettype none
`include "ast_map.vh"

module ast_top
(
    input wire sys_clk,
    input wire sys_rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg [31:0] hrdata,
    output reg hresp,
    output reg tx_out,
    output reg irq
);

reg [7:0] hold_r;
reg hold_full_r;
reg tx_flag_r;
reg ninth_val_r;
reg high_r;
reg sync_r;
reg transmit_enable_r;
reg nine_en_r;
reg inv_r;
reg wide_r;
reg serial_port_enable_r;
reg [7:0] div_lo_r;
reg [7:0] div_hi_r;
reg [7:0] pen_r;
reg [7:0] irqst_r;
reg [7:0] irqst_nxt;
reg gie_r;
reg peripheral_irq_enable_r;
reg wr_pend_r;
reg [7:0] wr_addr_r;
reg load_r;
reg [8:0] load_data_r;
reg load_nine_r;
reg [31:0] rdata_nxt;

wire addr_ok;
wire acc;
wire port_on;
wire run;
wire xfer;
wire hold_wr;
wire transmit_enable_set;
wire flag_rise;
wire sh_line;
wire sh_empty;
wire sh_done;
wire bit_tick;
wire [7:0] wdat;
wire [7:0] flag_view;

assign wdat = hwdata[7:0];
assign acc = hsel && htrans[1] && hready;
// only word-aligned addresses below 0x100 are mapped, at any size; the rest answers okay, reads zero
assign addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);

assign port_on = serial_port_enable_r && !sync_r;
assign run = port_on && transmit_enable_r;

assign hold_wr = wr_pend_r && (wr_addr_r == `AST_OFS_HOLD);
assign transmit_enable_set = wr_pend_r && (wr_addr_r == `AST_OFS_TXCTL) &&
    wdat[`AST_TXCTL_TRANSMIT_ENABLE] && !transmit_enable_r;

// move only when shifter idle, i.e. the stop bit has gone out
assign xfer = run && hold_full_r && sh_empty && !load_r;

assign flag_rise = (xfer || (transmit_enable_set && !hold_full_r)) && !hold_wr;
assign flag_view = {3'b000, tx_flag_r, 4'h0};

ast_baud u_baud
(
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .run(run),
    .wide(wide_r),
    .high(high_r),
    .divisor({div_hi_r, div_lo_r}),
    .bit_tick(bit_tick)
);

// the shifter reaches the bus only through its empty status, read in TXCTL bit 1, and its done pulse, latched in IRQST bit 1
ast_shift u_shift
(
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .abort(!run),
    .bit_tick(bit_tick),
    .load(load_r),
    .nine(load_nine_r),
    .data(load_data_r),
    .line(sh_line),
    .empty(sh_empty),
    .done(sh_done)
);

// read data is sampled in the address phase, so a read right behind a
// write to the same register sees the old value
always @*
begin
    rdata_nxt = `AST_RST_WORD;
    if (addr_ok)
    begin
        case (haddr[7:0])
            `AST_OFS_HOLD:
                rdata_nxt = {24'h000000, hold_r};
            `AST_OFS_TXCTL:
            begin
                rdata_nxt[`AST_TXCTL_NINTHVAL] = ninth_val_r;
                rdata_nxt[`AST_TXCTL_SHEMPTY] = sh_empty && !load_r;
                rdata_nxt[`AST_TXCTL_HIRATE] = high_r;
                rdata_nxt[`AST_TXCTL_SYNC] = sync_r;
                rdata_nxt[`AST_TXCTL_TRANSMIT_ENABLE] = transmit_enable_r;
                rdata_nxt[`AST_TXCTL_NINEEN] = nine_en_r;
            end
            `AST_OFS_BAUDCTL:
            begin
                rdata_nxt[`AST_BAUD_WIDE] = wide_r;
                rdata_nxt[`AST_BAUD_INV] = inv_r;
            end
            `AST_OFS_DIVLO:
                rdata_nxt = {24'h000000, div_lo_r};
            `AST_OFS_DIVHI:
                rdata_nxt = {24'h000000, div_hi_r};
            `AST_OFS_PFLAG:
                rdata_nxt = {24'h000000, flag_view};
            `AST_OFS_PEN:
                rdata_nxt = {24'h000000, pen_r};
            `AST_OFS_PORTCTL:
                rdata_nxt[`AST_PORT_SERIAL_PORT_ENABLE] = serial_port_enable_r;
            `AST_OFS_IRQST:
                rdata_nxt = {24'h000000, irqst_r};
            `AST_OFS_IRQCTL:
            begin
                rdata_nxt[`AST_IRQ_GLOBAL] = gie_r;
                rdata_nxt[`AST_IRQ_PERIPH] = peripheral_irq_enable_r;
            end
            default:
                rdata_nxt = `AST_RST_WORD;
        endcase
    end
end

// sticky events: set beats a write-one clear in the same cycle
always @*
begin
    irqst_nxt = irqst_r;
    if (wr_pend_r && (wr_addr_r == `AST_OFS_IRQST))
    begin
        irqst_nxt = irqst_r & ~wdat;
    end
    if (flag_rise)
    begin
        irqst_nxt[`AST_FLAG_TXBE] = 1'b1;
    end
    if (sh_done)
    begin
        irqst_nxt[`AST_FLAG_FRAME] = 1'b1;
    end
end

// bus slave: zero wait states, always okay
always @(posedge sys_clk)
begin
    if (sys_rst)
    begin
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        hrdata <= `AST_RST_WORD;
        wr_pend_r <= 1'b0;
        wr_addr_r <= `AST_RST_BYTE;
    end
    else
    begin
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        wr_pend_r <= acc && hwrite && addr_ok;
        if (acc)
        begin
            wr_addr_r <= haddr[7:0];
            hrdata <= hwrite ? `AST_RST_WORD : rdata_nxt;
        end
    end
end

// software-written configuration
always @(posedge sys_clk)
begin
    if (sys_rst)
    begin
        ninth_val_r <= 1'b0;
        high_r <= 1'b0;
        sync_r <= 1'b0;
        transmit_enable_r <= 1'b0;
        nine_en_r <= 1'b0;
        inv_r <= 1'b0;
        wide_r <= 1'b0;
        serial_port_enable_r <= 1'b0;
        div_lo_r <= `AST_RST_DIV;
        div_hi_r <= `AST_RST_DIV;
        pen_r <= `AST_RST_BYTE;
        gie_r <= 1'b0;
        peripheral_irq_enable_r <= 1'b0;
    end
    else if (wr_pend_r)
    begin
        case (wr_addr_r)
            `AST_OFS_TXCTL:
            begin
                ninth_val_r <= wdat[`AST_TXCTL_NINTHVAL];
                high_r <= wdat[`AST_TXCTL_HIRATE];
                sync_r <= wdat[`AST_TXCTL_SYNC];
                transmit_enable_r <= wdat[`AST_TXCTL_TRANSMIT_ENABLE];
                nine_en_r <= wdat[`AST_TXCTL_NINEEN];
            end
            `AST_OFS_BAUDCTL:
            begin
                wide_r <= wdat[`AST_BAUD_WIDE];
                inv_r <= wdat[`AST_BAUD_INV];
            end
            `AST_OFS_DIVLO:
                div_lo_r <= wdat;
            `AST_OFS_DIVHI:
                div_hi_r <= wdat;
            `AST_OFS_PEN:
                pen_r <= wdat;
            `AST_OFS_PORTCTL:
                serial_port_enable_r <= wdat[`AST_PORT_SERIAL_PORT_ENABLE];
            `AST_OFS_IRQCTL:
            begin
                gie_r <= wdat[`AST_IRQ_GLOBAL];
                peripheral_irq_enable_r <= wdat[`AST_IRQ_PERIPH];
            end
            default:
                serial_port_enable_r <= serial_port_enable_r;
        endcase
    end
end

// holding buffer, buffer-empty flag and the one-cycle move to the shifter;
// the flag register only has hardware writers, bus writes to it are dropped
always @(posedge sys_clk)
begin
    if (sys_rst)
    begin
        hold_r <= `AST_RST_BYTE;
        hold_full_r <= 1'b0;
        tx_flag_r <= 1'b0;
        load_r <= 1'b0;
        load_data_r <= 9'h1FF;
        load_nine_r <= 1'b0;
    end
    else
    begin
        load_r <= xfer;
        if (xfer)
        begin
            // ninth bit is taken at the move, so it must be set first
            load_data_r <= {ninth_val_r, hold_r};
            load_nine_r <= nine_en_r;
            hold_full_r <= 1'b0;
        end
        if (flag_rise)
        begin
            tx_flag_r <= 1'b1;
        end
        if (hold_wr)
        begin
            hold_r <= wdat;
            hold_full_r <= 1'b1;
            // drops one edge after the write, valid from the 2nd cycle
            tx_flag_r <= 1'b0;
        end
    end
end

// interrupt and line outputs, all from flops
always @(posedge sys_clk)
begin
    if (sys_rst)
    begin
        irqst_r <= `AST_RST_BYTE;
        irq <= 1'b0;
        tx_out <= 1'b1;
    end
    else
    begin
        irqst_r <= irqst_nxt;
        // the enable gates only the request, never the flag itself
        irq <= gie_r && peripheral_irq_enable_r && |(irqst_r & pen_r);
        tx_out <= sh_line ^ inv_r;
    end
end

endmodule // ast_top
`default_nettype wire

// ---- test/ast_chk_asserts.sv ----
// port checker for the serial transmitter
`timescale 1ns/100ps
`default_nettype none
module ast_chk
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic tx_out,
    input wire logic irq
);
    logic tk;
    logic wp_r;
    logic [7:0] wa_r;
    assign tk = hsel & htrans[1] & hready;
    // remembers the write address phase until its data phase ends
    always @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            wp_r <= 1'b0;
            wa_r <= 8'h00;
        end
        else if (hready)
        begin
            wp_r <= tk & hwrite;
            wa_r <= haddr[7:0];
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_reset_outputs: assert property (disable iff (1'b0) sys_rst |=>
        hreadyout && !hresp && !irq && tx_out && hrdata == 32'h0)
        else $error("outputs wrong after reset");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready okay");
    a_rdata_stands: assert property (!tk |=> $stable(hrdata))
        else $error("read data moved");
    a_unmapped_zero: assert property (tk && !hwrite &&
        haddr[31:8] != 24'h0 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (tk && !hwrite |=> hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_bit_hold: assert property ($changed(tx_out) |=>
        $stable(tx_out) [*8])
        else $error("line bit too short");
    a_irq_mask: assert property (wp_r && wa_r == 8'h18 &&
        hwdata[4] == 1'b0 && hwdata[1] == 1'b0 |-> ##2 !irq)
        else $error("masked interrupt still high");
    a_irq_gate: assert property (wp_r && wa_r == 8'h24 &&
        hwdata[7:6] != 2'h3 |-> ##2 !irq)
        else $error("gated interrupt still high");
    c_frame: cover property ($fell(tx_out));
    c_irq: cover property ($rose(irq));
    c_read: cover property (tk && !hwrite);
endmodule // ast_chk
bind ast_top ast_chk ast_chk_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .tx_out(tx_out), .irq(irq));
`default_nettype wire

// ---- test/ast_rx_model.sv ----
// remote receiver sampling the line in mid-bit, bit_len clocks a bit
`timescale 1ns/100ps
`default_nettype none
module ast_rx_model
(
    input wire logic sys_clk,
    input wire logic line,
    input wire logic inv,
    input wire logic nine,
    input wire logic [6:0] bit_len,
    output logic [8:0] data,
    output logic stop_bad,
    output int cnt
);
    logic [8:0] d;
    initial
    begin
        data = 9'h000;
        stop_bad = 1'b0;
        cnt = 0;
        forever
        begin
            @(posedge sys_clk);
            if ((line ^ inv) === 1'b0)
            begin
                d = 9'h000;
                repeat (bit_len / 2) @(posedge sys_clk);
                // a low shorter than half a bit, e.g. a polarity switch,
                // is no start bit
                if ((line ^ inv) === 1'b0)
                begin
                    for (int i = 0; i < (nine ? 9 : 8); i++)
                    begin
                        repeat (bit_len) @(posedge sys_clk);
                        d[i] = line ^ inv;
                    end
                    repeat (bit_len) @(posedge sys_clk);
                    stop_bad = (line ^ inv) !== 1'b1;
                    data = d;
                    cnt = cnt + 1;
                end
            end
        end
    end
endmodule // ast_rx_model
`default_nettype wire

// ---- test/tb_async_serial_transmitter.sv ----
// self-checking bench for the serial transmitter
`timescale 1ns/100ps
`default_nettype none
`include "ast_map.vh"
module tb_async_serial_transmitter;
    logic sys_clk, sys_rst, hsel, hwrite, inv, nine, stop_bad;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire hreadyout, hresp, tx_out, irq;
    wire [31:0] hrdata;
    logic [8:0] rx;
    logic [6:0] blen;
    int cnt, n_fail, total_checks;
    ast_top ast_top_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .tx_out(tx_out), .irq(irq));
    ast_rx_model ast_rx_model_inst (.sys_clk(sys_clk), .line(tx_out),
        .inv(inv), .nine(nine), .bit_len(blen), .data(rx),
        .stop_bad(stop_bad), .cnt(cnt));
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task rdy;
        int n;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
        begin
            n_fail++;
            end_of_test;
        end
    endtask
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        rdy;
        htrans <= 2'h0;
        hwdata <= d;
        rdy;
        rd = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, {24'h000000, a}, d);
    endtask
    task rg(input logic [7:0] a);
        bus(1'b0, {24'h000000, a}, 32'h00000000);
    endtask
    task wait_rx(input int n);
        for (int k = 0; k < 3000 && cnt < n; k++)
            @(posedge sys_clk);
        if (cnt < n)
        begin
            n_fail++;
            end_of_test;
        end
    endtask
    // irq is registered behind the enables, so allow a few cycles
    task wait_irq(input logic e);
        for (int k = 0; k < 4 && irq !== e; k++)
            @(posedge sys_clk);
        chk({31'h0, irq}, {31'h0, e});
    endtask
    task t_reset;
        rg(`AST_OFS_TXCTL);
        chk(rd, 32'h00000002);
        rg(`AST_OFS_PFLAG);
        chk(rd, 32'h00000000);
        wr(`AST_OFS_TXCTL, 32'h00000000);
        rg(`AST_OFS_TXCTL);
        chk(rd, 32'h00000002);
        bus(1'b1, 32'h00000100, 32'h000000FF);
        bus(1'b0, 32'h00000100, 32'h00000000);
        chk(rd, 32'h00000000);
        $display("test reset done");
    endtask
    task t_enable;
        wr(`AST_OFS_DIVLO, 32'h00000000);
        wr(`AST_OFS_DIVHI, 32'h00000000);
        wr(`AST_OFS_PORTCTL, 32'h00000080);
        wr(`AST_OFS_TXCTL, 32'h00000024);
        rg(`AST_OFS_PFLAG);
        chk(rd, 32'h00000010);
        wr(`AST_OFS_PFLAG, 32'h00000000);
        rg(`AST_OFS_PFLAG);
        chk(rd, 32'h00000010);
        rg(`AST_OFS_IRQST);
        chk(rd, 32'h00000010);
        $display("test enable done");
    endtask
    task t_frames;
        wr(`AST_OFS_HOLD, 32'h000000A5);
        wr(`AST_OFS_HOLD, 32'h0000003C);
        rg(`AST_OFS_PFLAG);
        chk(rd, 32'h00000000);
        rg(`AST_OFS_TXCTL);
        chk(rd, 32'h00000024);
        wait_rx(1);
        chk({23'h0, rx}, 32'h000000A5);
        wait_rx(2);
        chk({23'h0, rx}, 32'h0000003C);
        chk({31'h0, stop_bad}, 32'h0);
        for (int k = 0; k < 20 && rd[1] !== 1'b1; k++)
            rg(`AST_OFS_TXCTL);
        chk(rd, 32'h00000026);
        rg(`AST_OFS_PFLAG);
        chk(rd, 32'h00000010);
        $display("test frames done");
    endtask
    task t_irq;
        wr(`AST_OFS_PEN, 32'h00000010);
        wr(`AST_OFS_IRQCTL, 32'h000000C0);
        wait_irq(1'b1);
        wr(`AST_OFS_PEN, 32'h00000000);
        wait_irq(1'b0);
        wr(`AST_OFS_PEN, 32'h00000010);
        wait_irq(1'b1);
        wr(`AST_OFS_IRQST, 32'h00000012);
        wait_irq(1'b0);
        rg(`AST_OFS_IRQST);
        chk(rd, 32'h00000000);
        wr(`AST_OFS_IRQCTL, 32'h00000000);
        wait_irq(1'b0);
        $display("test irq done");
    endtask
    task t_nine_inv;
        wr(`AST_OFS_BAUDCTL, 32'h00000010);
        inv <= 1'b1;
        nine <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk({31'h0, tx_out}, 32'h0);
        wr(`AST_OFS_TXCTL, 32'h00000065);
        wr(`AST_OFS_HOLD, 32'h0000005A);
        wait_rx(3);
        chk({23'h0, rx}, 32'h0000015A);
        chk({31'h0, stop_bad}, 32'h0);
        $display("test ninth bit inverted done");
    endtask
    task t_modes;
        blen <= 7'h40;
        wr(`AST_OFS_TXCTL, 32'h00000071);
        wr(`AST_OFS_HOLD, 32'h000000C3);
        repeat (200) @(posedge sys_clk);
        chk(cnt, 32'h00000003);
        chk({31'h0, tx_out}, 32'h0);
        rg(`AST_OFS_PFLAG);
        chk(rd, 32'h00000000);
        // high rate is already clear from the sync write, so after clearing sync bits run x64
        wr(`AST_OFS_TXCTL, 32'h00000061);
        wait_rx(4);
        chk({23'h0, rx}, 32'h000001C3);
        chk({31'h0, stop_bad}, 32'h0);
        $display("test sync and slow rate done");
    endtask
    initial
    begin
        sys_rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        inv = 1'b0;
        nine = 1'b0;
        blen = 7'h10;
        n_fail = 0;
        total_checks = 0;
        rd = 32'h0;
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset;
        t_enable;
        t_frames;
        t_irq;
        t_nine_inv;
        t_modes;
        end_of_test;
    end
endmodule // tb_async_serial_transmitter
`default_nettype wire
